// ---- sdi_map.svh ----
/*
  Constants of the memory init and mode block: pin fields, mode register
  layout and encodings, timing figures and the control register map.
  Assumes it is included by bare name before any module that uses it.
*/
`ifndef SDI_MAP_SVH
`define SDI_MAP_SVH

// ----------------------------------------------------------------------
// pins and sizes
// ----------------------------------------------------------------------
`define SDI_ADDR_W     12
`define SDI_DATA_W     16
`define SDI_DQM_W      2
`define SDI_COL_W      8
`define SDI_COL_MSB    7
`define SDI_IGN_MSB    9
`define SDI_IGN_LSB    8
`define SDI_PALL_BIT   10
`define SDI_BANK_BIT   11

// ----------------------------------------------------------------------
// mode register fields and encodings
// ----------------------------------------------------------------------
`define SDI_LEN_MSB    2
`define SDI_LEN_LSB    0
`define SDI_ORD_BIT    3
`define SDI_LAT_MSB    6
`define SDI_LAT_LSB    4
`define SDI_OPT_LSB    7
`define SDI_WM_MSB     11
`define SDI_WM_LSB     9
`define SDI_LEN_1      3'h0
`define SDI_LEN_8      3'h3
`define SDI_LEN_PAGE   3'h7
`define SDI_LAT_2      3'h2
`define SDI_LAT_3      3'h3
`define SDI_WM_BURST   3'h0
`define SDI_WM_SINGLE  3'h1
`define SDI_MODE_RST   12'h022

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SDI_STABLE_US  100
`define SDI_CLK_MHZ    100
`define SDI_MCD_CYC    2'h2
`define SDI_MIN_REF    2'h2

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define SDI_AXI_AW     8
`define SDI_OFS_CTRL   8'h00
`define SDI_OFS_STAT   8'h04
`define SDI_OFS_MODE   8'h08
`define SDI_STRICT_BIT 0
`define SDI_READY_BIT  2
`define SDI_ESEQ_BIT   8
`define SDI_EMCD_BIT   9
`define SDI_RESP_OKAY  2'h0
`define SDI_RESP_SLV   2'h2

`endif

// ---- sdi_pkg.sv ----
/*
  Types of the memory init and mode block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sdi_pkg;
  typedef enum logic [1:0] {
    sdi_st_stable,
    sdi_st_precharge,
    sdi_st_refresh,
    sdi_st_ready
  } sdi_init_t;
endpackage

// ---- sdi_mem.sv ----
/*
  Cell array of the memory: one write port with byte enables, one read
  port whose data come out of a register one clock after the address.
  Assumes a single clock; no reset, contents are undefined at power-up.
*/
`timescale 1ns/1ps
`default_nettype none
module sdi_mem #(
  parameter int unsigned AW = 9,
  parameter int unsigned DW = 16
) (
  // clock
  input  wire logic          aclk,
  // write port
  input  wire logic          we,
  input  wire logic [DW/8-1:0] be,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] cells [2**AW];

  always_ff @(posedge aclk) begin
    for (int i = 0; i < DW / 8; i++) begin
      if (we && be[i]) begin
        cells[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
      end
    end
    rdata <= cells[raddr];
  end
endmodule
`default_nettype wire

// ---- sdi_top.sv ----
/*
  Device side of a two-bank synchronous memory: watches the power-on
  sequence, holds the mode register, runs bursts and read latency, and
  exposes control and status over AXI4-Lite.
  Assumes command pins are synchronous to aclk; controller keeps its own
  sequencing, which is watched and flagged here; strict mode also drops accesses before ready.
*/
// Function
// RULE1: controller holds enable and mask high first
// RULE2: precharge of both banks comes first
// RULE3: two refreshes and mode load before use
// RULE4: mode load accepted before or after refreshes
// RULE5: mode load captures address pins as code
// RULE6: code splits into options, latency, order, length
// RULE7: mode load only with both banks idle
// RULE8: two quiet cycles after mode load
// RULE9: read data appear after programmed latency
// RULE10: burst starts at given column, then self-generated
// RULE11: length field selects 1,2,4,8 or page
// RULE12: order bit picks sequential or interleaved
// RULE13: write mode zero gives burst writes
// RULE14: burst write data taken with command
// RULE15: single write mode stores exactly one word
// RULE16: two column address pins are ignored
// RULE17: full page runs 256 columns, wrapping
// RULE18: only burst and single write modes used
// RULE19: latency field gives two or three clocks
// RULE20: mode held until next load, applied always
// RULE21: no access before initialization completes; code drops them only with strict set, else performs and flags them
`timescale 1ns/1ps
`default_nettype none
`include "sdi_map.svh"
module sdi_top #(
  parameter int unsigned STABLE_CYC = `SDI_STABLE_US * `SDI_CLK_MHZ,
  parameter int unsigned COL_W      = `SDI_COL_W
) (
  // clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // axi4-lite slave
  input  wire logic [`SDI_AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`SDI_AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // memory pins
  input  wire logic                     cke,
  input  wire logic                     cs_n,
  input  wire logic                     ras_n,
  input  wire logic                     cas_n,
  input  wire logic                     we_n,
  input  wire logic [`SDI_ADDR_W-1:0]   addr,
  input  wire logic [`SDI_DQM_W-1:0]    dqm,
  input  wire logic [`SDI_DATA_W-1:0]   dq_in,
  output logic      [`SDI_DATA_W-1:0]   dq_out,
  output logic                          dq_oe_n,
  // status
  output sdi_pkg::sdi_init_t            init_state
);
  import sdi_pkg::*;

  localparam int unsigned SW = $clog2(STABLE_CYC + 1);
  localparam int unsigned MW = COL_W + 1;
  localparam logic [COL_W:0] FULL = {1'b1, {COL_W{1'b0}}};
  localparam logic [COL_W:0] ONE  = {{COL_W{1'b0}}, 1'b1};

  // ----------------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------------
  function automatic logic [COL_W:0] burst_len(input logic [2:0] lc,
                                               input logic       ilv);
    logic [COL_W:0] len;
    len = ONE;
    if (lc <= `SDI_LEN_8) len = ONE << lc;
    else if (lc == `SDI_LEN_PAGE && !ilv) len = FULL;
    return len;
  endfunction

  function automatic logic [COL_W-1:0] col_at(input logic [COL_W-1:0] st,
                                              input logic [COL_W-1:0] ix,
                                              input logic [COL_W-1:0] mk,
                                              input logic             ilv);
    logic [COL_W-1:0] low;
    low = ilv ? (st ^ ix) : COL_W'(st + ix);
    return (st & ~mk) | (low & mk);
  endfunction

  logic cmd_on, busy_cmd, is_mode, is_ref, is_pall, is_act, is_rw, is_wr;
  logic is_bst, is_pre;
  assign cmd_on   = cke && !cs_n;
  assign busy_cmd = cmd_on && !(ras_n && cas_n && we_n);
  assign is_mode  = cmd_on && !ras_n && !cas_n && !we_n;
  assign is_ref   = cmd_on && !ras_n && !cas_n && we_n;
  assign is_pre   = cmd_on && !ras_n && cas_n && !we_n;
  assign is_pall  = is_pre && addr[`SDI_PALL_BIT];
  assign is_act   = cmd_on && !ras_n && cas_n && we_n;
  assign is_rw    = cmd_on && ras_n && !cas_n;
  assign is_wr    = is_rw && !we_n;
  assign is_bst   = cmd_on && ras_n && cas_n && !we_n;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  sdi_init_t                st, next_st;
  logic [SW-1:0]            scnt, next_scnt;
  logic [1:0]               refs, next_refs, mcd, next_mcd;
  logic                     mdone, next_mdone, eseq, next_eseq;
  logic                     emcd, next_emcd, strict, next_strict;
  logic [`SDI_ADDR_W-1:0]   mode, next_mode;
  logic                     b_act, next_b_act, b_wr, next_b_wr;
  logic                     b_bank, next_b_bank, b_ilv, next_b_ilv;
  logic [COL_W-1:0]         b_start, next_b_start, b_mask, next_b_mask;
  logic [COL_W:0]           b_idx, next_b_idx, b_len, next_b_len;
  logic                     aw_got, next_aw_got, w_got, next_w_got;
  logic [`SDI_AXI_AW-1:0]   aw_q, next_aw_q;
  logic [31:0]              w_q, next_w_q, next_rdata;
  logic [3:0]               ws_q, next_ws_q;
  logic                     next_awready, next_wready, next_bvalid;
  logic                     next_arready, next_rvalid;
  logic [1:0]               next_bresp, next_rresp;
  logic                     clr_seq, clr_mcd, rw_ok;
  logic                     acc_go, acc_wr, acc_bank;
  logic [COL_W-1:0]         acc_col;
  logic [`SDI_DATA_W-1:0]   mem_rdata, p1_data;
  logic                     rv0, p1_v, lat3;
  logic [2:0]               wmode;

  assign rw_ok = !strict || st == sdi_st_ready;  // [RULE21]
  assign lat3  = mode[`SDI_LAT_MSB:`SDI_LAT_LSB] != `SDI_LAT_2;  // [RULE19]
  assign wmode = mode[`SDI_WM_MSB:`SDI_WM_LSB];  // [RULE6]

  // ----------------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------------
  always_comb begin
    next_aw_got = aw_got;
    next_w_got  = w_got;
    next_aw_q   = aw_q;
    next_w_q    = w_q;
    next_ws_q   = ws_q;
    next_bvalid = s_axi_bvalid;
    next_bresp  = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    next_strict = strict;
    clr_seq     = 1'b0;
    clr_mcd     = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_aw_q   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_w_q   = s_axi_wdata;
      next_ws_q  = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) next_bvalid = 1'b0;
    if (aw_got && w_got && !s_axi_bvalid) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = `SDI_RESP_OKAY;
      if (aw_q == `SDI_OFS_CTRL) begin
        if (ws_q[0]) next_strict = w_q[`SDI_STRICT_BIT];
      end else if (aw_q == `SDI_OFS_STAT) begin
        clr_seq = ws_q[1] && w_q[`SDI_ESEQ_BIT];
        clr_mcd = ws_q[1] && w_q[`SDI_EMCD_BIT];
      end else if (aw_q != `SDI_OFS_MODE) begin
        next_bresp = `SDI_RESP_SLV;
      end
    end
    if (s_axi_rvalid && s_axi_rready) next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = '0;
      next_rresp  = `SDI_RESP_OKAY;
      if (s_axi_araddr == `SDI_OFS_CTRL) begin
        next_rdata[`SDI_STRICT_BIT] = strict;
      end else if (s_axi_araddr == `SDI_OFS_STAT) begin
        next_rdata[1:0]            = st;
        next_rdata[`SDI_READY_BIT] = st == sdi_st_ready;
        next_rdata[`SDI_ESEQ_BIT]  = eseq;
        next_rdata[`SDI_EMCD_BIT]  = emcd;
      end else if (s_axi_araddr == `SDI_OFS_MODE) begin
        next_rdata[`SDI_ADDR_W-1:0] = mode;
      end else begin
        next_rresp = `SDI_RESP_SLV;
      end
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready  = !next_w_got && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_q          <= '0;
      w_q           <= '0;
      ws_q          <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SDI_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `SDI_RESP_OKAY;
      strict        <= 1'b0;
    end else begin
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      aw_q          <= next_aw_q;
      w_q           <= next_w_q;
      ws_q          <= next_ws_q;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      strict        <= next_strict;
    end
  end

  // ----------------------------------------------------------------------
  // power-on sequence watch
  // ----------------------------------------------------------------------
  // controller faults are flagged; with strict set, reads and writes before ready are also dropped
  always_comb begin
    next_st    = st;
    next_scnt  = scnt;
    next_refs  = refs;
    next_mdone = mdone;
    next_mcd   = mcd;
    next_eseq  = eseq && !clr_seq;
    next_emcd  = emcd && !clr_mcd;
    if (mcd != 2'h0) next_mcd = mcd - 2'h1;
    if (busy_cmd && mcd != 2'h0) next_emcd = 1'b1;  // [RULE8]
    if (is_mode && (b_act || st != sdi_st_refresh && st != sdi_st_ready &&
        st != sdi_st_precharge)) next_eseq = 1'b1;  // [RULE7]
    if (is_mode) begin
      next_mcd   = `SDI_MCD_CYC;
      next_mdone = 1'b1;
    end
    if (is_mode && addr[`SDI_WM_MSB:`SDI_WM_LSB] > `SDI_WM_SINGLE)
      next_eseq = 1'b1;  // [RULE18]
    unique case (st)
      sdi_st_stable: begin
        next_scnt = (cke && &dqm) ? SW'(scnt + 1'b1) : '0;  // [RULE1]
        if (busy_cmd) next_eseq = 1'b1;
        if (scnt == SW'(STABLE_CYC)) next_st = sdi_st_precharge;
      end
      sdi_st_precharge: begin
        if (is_pall) next_st = sdi_st_refresh;  // [RULE2]
        else if (busy_cmd && !is_mode) next_eseq = 1'b1;
      end
      sdi_st_refresh: begin
        if (is_ref && refs != 2'h3) next_refs = refs + 2'h1;
        if (is_rw || is_act) next_eseq = 1'b1;  // [RULE21]
        // mode load may sit before or after the refreshes
        if (refs >= `SDI_MIN_REF && mdone && mcd == 2'h0)
          next_st = sdi_st_ready;  // [RULE3] [RULE4]
      end
      sdi_st_ready: begin
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st    <= sdi_st_stable;
      scnt  <= '0;
      refs  <= 2'h0;
      mdone <= 1'b0;
      mcd   <= 2'h0;
      eseq  <= 1'b0;
      emcd  <= 1'b0;
    end else begin
      st    <= next_st;
      scnt  <= next_scnt;
      refs  <= next_refs;
      mdone <= next_mdone;
      mcd   <= next_mcd;
      eseq  <= next_eseq;
      emcd  <= next_emcd;
    end
  end
  assign init_state = st;

  // ----------------------------------------------------------------------
  // mode register and burst engine
  // ----------------------------------------------------------------------
  always_comb begin
    next_mode    = mode;
    next_b_act   = b_act;
    next_b_wr    = b_wr;
    next_b_bank  = b_bank;
    next_b_ilv   = b_ilv;
    next_b_start = b_start;
    next_b_mask  = b_mask;
    next_b_idx   = b_idx;
    next_b_len   = b_len;
    acc_go       = 1'b0;
    acc_wr       = 1'b0;
    acc_bank     = 1'b0;
    acc_col      = '0;
    if (is_mode) next_mode = addr;  // [RULE5] [RULE20]
    if (is_rw && rw_ok) begin
      acc_go       = 1'b1;
      acc_wr       = is_wr;  // [RULE14]
      acc_bank     = addr[`SDI_BANK_BIT];
      acc_col      = addr[COL_W-1:0];  // [RULE16] [RULE10]
      next_b_wr    = is_wr;
      next_b_bank  = addr[`SDI_BANK_BIT];
      next_b_start = addr[COL_W-1:0];
      next_b_ilv   = mode[`SDI_ORD_BIT];  // [RULE12]
      next_b_len   = burst_len(mode[`SDI_LEN_MSB:`SDI_LEN_LSB],
                               mode[`SDI_ORD_BIT]);  // [RULE11] [RULE17]
      if (is_wr && wmode == `SDI_WM_SINGLE) next_b_len = ONE;  // [RULE15]
      next_b_mask  = COL_W'(next_b_len - ONE);
      next_b_idx   = ONE;
      next_b_act   = next_b_len > ONE;  // [RULE13]
    end else if (is_bst || is_pre) begin
      next_b_act = 1'b0;
    end else if (b_act) begin
      acc_go     = 1'b1;
      acc_wr     = b_wr;
      acc_bank   = b_bank;
      acc_col    = col_at(b_start, b_idx[COL_W-1:0], b_mask, b_ilv);
      next_b_idx = b_idx + ONE;
      next_b_act = next_b_idx < b_len;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode    <= `SDI_MODE_RST;
      b_act   <= 1'b0;
      b_wr    <= 1'b0;
      b_bank  <= 1'b0;
      b_ilv   <= 1'b0;
      b_start <= '0;
      b_mask  <= '0;
      b_idx   <= '0;
      b_len   <= '0;
    end else begin
      mode    <= next_mode;
      b_act   <= next_b_act;
      b_wr    <= next_b_wr;
      b_bank  <= next_b_bank;
      b_ilv   <= next_b_ilv;
      b_start <= next_b_start;
      b_mask  <= next_b_mask;
      b_idx   <= next_b_idx;
      b_len   <= next_b_len;
    end
  end

  sdi_mem #(
    .AW (MW),
    .DW (`SDI_DATA_W)
  ) u_mem (
    .aclk  (aclk),
    .we    (acc_go && acc_wr),
    .be    (~dqm),
    .waddr ({acc_bank, acc_col}),
    .wdata (dq_in),
    .raddr ({acc_bank, acc_col}),
    .rdata (mem_rdata)
  );

  // ----------------------------------------------------------------------
  // read latency pipe
  // ----------------------------------------------------------------------
  // reserved latency codes fall back to the longer setting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rv0     <= 1'b0;
      p1_v    <= 1'b0;
      p1_data <= '0;
      dq_out  <= '0;
      dq_oe_n <= 1'b1;
    end else begin
      rv0     <= acc_go && !acc_wr;
      p1_v    <= rv0;
      p1_data <= mem_rdata;
      dq_out  <= lat3 ? p1_data : mem_rdata;  // [RULE9]
      dq_oe_n <= lat3 ? !p1_v : !rv0;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic quiet;
  assign quiet = !is_rw && !is_bst && !is_pre;

  chk_mode_capture: assert property (is_mode |=> mode == $past(addr)) // [RULE5]
    else $error("mode register missed the address pins");
  chk_mode_hold: assert property (!is_mode |=> $stable(mode)) // [RULE20]
    else $error("mode register changed without a load");
  chk_lat_two: assert property (is_rw && we_n && rw_ok && !lat3 // [RULE9]
    |-> ##2 !dq_oe_n)
    else $error("read data missed latency two");
  chk_lat_three: assert property (is_rw && we_n && rw_ok && lat3 // [RULE19]
    ##1 !is_mode |-> ##2 !dq_oe_n)
    else $error("read data missed latency three");
  chk_write_first: assert property (is_wr && rw_ok // [RULE14]
    |-> acc_go && acc_wr && acc_col == addr[COL_W-1:0])
    else $error("burst write did not start with the command");
  chk_col_ignore: assert property (is_rw && rw_ok // [RULE16]
    |=> {b_bank, b_start} == $past({addr[`SDI_BANK_BIT], addr[COL_W-1:0]}))
    else $error("column taken from ignored pins");
  chk_single_write: assert property (is_wr && rw_ok // [RULE15]
    && wmode == `SDI_WM_SINGLE |=> !b_act)
    else $error("single write ran a burst");
  chk_burst_four: assert property (is_wr && rw_ok && wmode == `SDI_WM_BURST
    && mode[2:0] == 3'h2 ##1 quiet[*3] |=> !b_act) // [RULE11]
    else $error("burst of four ran the wrong length");
  chk_seq_order: assert property (b_act && !b_ilv && quiet && // [RULE12]
    b_idx > ONE |-> (acc_col & b_mask) == ((($past(acc_col)) + 1'b1) & b_mask))
    else $error("sequential burst skipped a column");
  chk_page_len: assert property (is_rw && rw_ok && we_n && // [RULE17]
    mode[3:0] == 4'h7 |=> b_len == FULL)
    else $error("full page burst length wrong");
endmodule
`default_nettype wire

// ---- sdi_ctl_model.sv ----
/*
  Memory controller model: drives command, address, mask and write data.
  Assumes one bench process calls its tasks, after reset is released.
*/
`timescale 1ns/1ps
`default_nettype none
module sdi_ctl_model (
  // clock
  input  wire logic        aclk,
  // command pins
  output logic             cke,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [11:0]      addr,
  output logic [1:0]       dqm,
  output logic [15:0]      dq_in
);
  initial begin
    cke = 1'b1;
    dqm = 2'b11;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'b111;
    addr = 12'h000;
    dq_in = 16'h0000;
  end
  // one command per call, launched just after an edge
  task issue(input logic [2:0] c, input logic [11:0] a,
             input logic [15:0] d);
    @(posedge aclk);
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= c;
    addr <= a;
    dq_in <= d;
  endtask
  // data not held in quiet cycles: keep it moving
  task nop();
    issue(3'b111, ~addr, ~dq_in);
  endtask
  // no row is ever opened, so banks are idle here
  task mode_load(input logic [11:0] code);
    issue(3'b000, code, 16'h0000);
    repeat (2) nop();
  endtask
  task init_seq(input logic [11:0] code);
    issue(3'b010, 12'h400, 16'h0000);
    nop();
    repeat (2) begin
      issue(3'b001, 12'h000, 16'h0000);
      nop();
    end
    mode_load(code);
    dqm <= 2'b00;
  endtask
endmodule
`default_nettype wire

// ---- tb_sdi_top.sv ----
/*
  Bench of the memory init and mode block, with a controller model.
  Assumes a 100 MHz clock and the block's own bus and pin timing.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdi_map.svh"
module tb_sdi_top;
  import sdi_pkg::*;
  localparam int STB = 20;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  wire logic awready, wready, bvalid, arready, rvalid, dq_oe_n;
  wire logic cke, cs_n, ras_n, cas_n, we_n;
  wire logic [1:0] bresp, rresp, dqm;
  wire logic [31:0] rdata;
  wire logic [11:0] addr;
  wire logic [15:0] dq_in, dq_out;
  sdi_init_t init_state;
  int n_errors = 0, n_checks = 0;
  logic [15:0] emem [256];
  bit known [256];
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  sdi_top #(.STABLE_CYC(STB)) u_sdi_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .dqm(dqm),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .init_state(init_state));
  sdi_ctl_model u_sdi_ctl_model (.aclk(aclk), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .dqm(dqm),
    .dq_in(dq_in));
  // ---------------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------------
  task end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task tmo(input bit bad);
    if (bad) begin
      n_errors++;
      $display("unexpected at %0t: no answer", $time);
      end_of_test();
    end
  endtask
  task axi_rd(input logic [7:0] a, input logic [31:0] e,
              input logic [1:0] er);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50 && rvalid !== 1'b1; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    tmo(i >= 50);
    rready <= 1'b0;
    chk(rdata, e);
    chk(rresp, er);
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    {awvalid, wvalid, bready} <= 3'b111;
    for (i = 0; i < 50 && bvalid !== 1'b1; i++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    tmo(i >= 50);
    bready <= 1'b0;
    chk(bresp, `SDI_RESP_OKAY);
  endtask
  function automatic logic [7:0] colk(input logic [7:0] c, input int k,
                                      input int n, input bit ilv);
    logic [7:0] m;
    m = n[7:0] - 8'h01;
    if (ilv) return c ^ k[7:0];
    return (c & ~m) | ((c + k[7:0]) & m);
  endfunction
  task wr(input logic [7:0] c, input int n, input bit ilv, input bit one,
          input logic [7:0] tg);
    int k;
    logic [7:0] ck;
    for (k = 0; k < n; k++) begin
      ck = colk(c, k, n, ilv);
      u_sdi_ctl_model.issue(k == 0 ? 3'b100 : 3'b111,
                            k == 0 ? {4'h0, c} : 12'h000, {tg, ck});
      if (k == 0 || !one) begin
        emem[ck] = {tg, ck};
        known[ck] = 1'b1;
      end
    end
    u_sdi_ctl_model.nop();
  endtask
  task rd(input logic [11:0] a, input int lat, input int n, input bit ilv);
    int k;
    logic [7:0] ck;
    u_sdi_ctl_model.issue(3'b101, a, 16'h0000);
    u_sdi_ctl_model.nop();
    repeat (lat - 1) @(posedge aclk);
    for (k = 0; k < n; k++) begin
      #1;
      ck = colk(a[7:0], k, n, ilv);
      chk(dq_oe_n, 1'b0);
      if (known[ck]) chk(dq_out, emem[ck]);
      @(posedge aclk);
    end
    #1;
    chk(dq_oe_n, 1'b1);
  endtask
  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  task t_init();
    int i;
    repeat (STB - 4) @(posedge aclk);
    #1;
    chk(init_state, sdi_st_stable);
    for (i = 0; i < 10 && init_state !== sdi_st_precharge; i++)
      @(posedge aclk);
    tmo(i >= 10);
    axi_rd(`SDI_OFS_MODE, 32'h0000_0022, `SDI_RESP_OKAY);
    u_sdi_ctl_model.init_seq(12'h023);
    for (i = 0; i < 6 && init_state !== sdi_st_ready; i++)
      @(posedge aclk);
    chk(init_state, sdi_st_ready);
    axi_rd(`SDI_OFS_STAT, 32'h0000_0007, `SDI_RESP_OKAY);
    axi_rd(`SDI_OFS_MODE, 32'h0000_0023, `SDI_RESP_OKAY);
    $display("test init done");
  endtask
  task t_burst();
    wr(8'h03, 8, 1'b0, 1'b0, 8'ha5);
    rd(12'h005, 2, 8, 1'b0);
    axi_wr(`SDI_OFS_MODE, 32'h0000_0fff);
    axi_rd(`SDI_OFS_MODE, 32'h0000_0023, `SDI_RESP_OKAY);
    axi_rd(8'h0c, 32'h0000_0000, `SDI_RESP_SLV);
    $display("test burst done");
  endtask
  task t_single();
    u_sdi_ctl_model.mode_load(12'h23b);
    axi_rd(`SDI_OFS_MODE, 32'h0000_023b, `SDI_RESP_OKAY);
    wr(8'h06, 8, 1'b1, 1'b1, 8'hc3);
    rd(12'h305, 3, 8, 1'b1);
    axi_rd(`SDI_OFS_STAT, 32'h0000_0007, `SDI_RESP_OKAY);
    $display("test single done");
  endtask
  task t_page();
    u_sdi_ctl_model.issue(3'b000, 12'h022, 16'h0000);
    u_sdi_ctl_model.issue(3'b001, 12'h000, 16'h0000);
    u_sdi_ctl_model.nop();
    axi_rd(`SDI_OFS_STAT, 32'h0000_0207, `SDI_RESP_OKAY);
    axi_wr(`SDI_OFS_STAT, 32'h0000_0200);
    axi_rd(`SDI_OFS_STAT, 32'h0000_0007, `SDI_RESP_OKAY);
    wr(8'h09, 4, 1'b0, 1'b0, 8'h5a);
    rd(12'h00a, 2, 4, 1'b0);
    u_sdi_ctl_model.mode_load(12'h027);
    rd(12'h000, 2, 256, 1'b0);
    $display("test page done");
  endtask
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_init();
    t_burst();
    t_single();
    t_page();
    end_of_test();
  end
endmodule
`default_nettype wire
